//--- rtl/dsp_operand_legality_decode.v
// Instruction decoder with operand legality checks for the DSP core.
// Assumes instruction words arrive from program memory on ref_clk with a
// one-cycle valid strobe; no back-pressure is offered or needed.
//
// Functional notes
// - A load whose hardware-register destination is the product register is illegal.
// - A hardware-register load naming the same offchip_reg_n as source and destination is illegal.
// - A hardware-register load with X as both ends, or status_register as both ends, is illegal.
// - A load from an accumulator-indirect source into the accumulator is illegal.
// - A pointer-indirect first multiply source must use a bank 1 pointer.
// - A pointer-indirect second multiply source must use a bank 0 pointer.
// - A hardware-register first multiply source must not be X.
// - With a register first source and no switch operand, the bank switch defaults OFF.
// - With two pointer-indirect sources and no switch operand, the bank switch defaults ON.
// - The optional third multiply operand sets the bank switch and reaches operand selection.
// - Operand selection allows a value to be multiplied by itself.
`timescale 1ns/1ps
`include "dsp_decode_defines.vh"

module dsp_operand_legality_decode (
  input wire ref_clk,
  input wire rst_n,
  input wire instr_valid,
  input wire [15:0] instr_word,
  output reg dec_valid_r,
  output reg exec_valid_r,
  output reg illegal_r,
  output reg [3:0] illegal_cause_r,
  output reg [3:0] dec_op_r,
  output reg [2:0] dest_cls_r,
  output reg [2:0] src_cls_r,
  output reg [3:0] dest_reg_r,
  output reg [3:0] src_reg_r,
  output reg [15:0] imm_r,
  output reg bank_sw_r,
  output reg src1_bank_r,
  output reg src2_bank_r,
  output reg [1:0] ptr1_r,
  output reg [1:0] ptr2_r,
  output reg [1:0] ptr2_mod_r
);

  // --------------------------------------------------------------------------
  // States of the word sequencer
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_IMM = 1'b1;

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // True when a hardware-register code names an off-chip register.
  function is_ext;
    input [3:0] code;
    begin
      is_ext = code[`HW_EXT_BIT];
    end
  endfunction

  // True for opcodes of the multiply family.
  function is_mul;
    input [3:0] op;
    begin
      is_mul = (op == `OP_MUL_LOAD) || (op == `OP_MUL_ACC) || (op == `OP_MUL_SUB);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Field extraction
  // --------------------------------------------------------------------------
  wire [3:0] op = instr_word[`OP_MSB:`OP_LSB];
  wire [2:0] ld_dcls = instr_word[`LD_DCLS_MSB:`LD_DCLS_LSB];
  wire [2:0] ld_scls = instr_word[`LD_SCLS_MSB:`LD_SCLS_LSB];
  wire [3:0] ld_reg = instr_word[`LD_REG_MSB:`LD_REG_LSB];
  wire [3:0] hh_dst = instr_word[`HH_DST_MSB:`HH_DST_LSB];
  wire [3:0] hh_src = instr_word[`HH_SRC_MSB:`HH_SRC_LSB];

  wire mul_illegal;
  wire [3:0] mul_cause;
  wire mul_bank_sw;
  wire mul_src2_bank;

  reg state_r;
  reg state_nxt;
  reg ld_illegal;
  reg [3:0] ld_cause;

  // Holding registers for a two-word load while its immediate is awaited.
  reg hold_illegal_r;
  reg [3:0] hold_cause_r;
  reg [2:0] hold_dcls_r;
  reg [3:0] hold_dreg_r;

  // --------------------------------------------------------------------------
  // Multiply operand checker
  // --------------------------------------------------------------------------
  mul_operand_check u_mul_check (
    .word(instr_word),
    .illegal(mul_illegal),
    .cause(mul_cause),
    .bank_sw(mul_bank_sw),
    .src2_bank(mul_src2_bank)
  );

  // --------------------------------------------------------------------------
  // Load legality
  // --------------------------------------------------------------------------
  // One cause is reported, the first in this order, even when several apply.
  always @* begin
    ld_illegal = 1'b0;
    ld_cause = `CAUSE_NONE;
    if (op == `OP_LOAD_HH) begin
      if (hh_dst == `HW_PROD) begin
        ld_illegal = 1'b1;
        ld_cause = `CAUSE_DST_PROD;
      end else if (is_ext(hh_dst) && is_ext(hh_src) && hh_dst == hh_src) begin
        ld_illegal = 1'b1;
        ld_cause = `CAUSE_EXT_SAME;
      end else if (hh_dst == `HW_X && hh_src == `HW_X) begin
        ld_illegal = 1'b1;
        ld_cause = `CAUSE_X_SAME;
      end else if (hh_dst == `HW_STATUS && hh_src == `HW_STATUS) begin
        ld_illegal = 1'b1;
        ld_cause = `CAUSE_SR_SAME;
      end
    end else if (op == `OP_LOAD) begin
      if (ld_dcls == `CLS_HWREGS && ld_reg == `HW_PROD) begin
        ld_illegal = 1'b1;
        ld_cause = `CAUSE_DST_PROD;
      end else if (ld_scls == `CLS_ACCIND && ld_dcls == `CLS_HWREGS && ld_reg == `HW_ACC) begin
        ld_illegal = 1'b1;
        ld_cause = `CAUSE_ACCIND_ACC;
      end else if (ld_dcls == `CLS_MEMIND || ld_dcls == `CLS_ACCIND ||
                   ld_dcls == `CLS_LIMM) begin
        ld_illegal = 1'b1;
        ld_cause = `CAUSE_BAD_DEST;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Word sequencer
  // --------------------------------------------------------------------------
  // A load with a long immediate takes two words; the second must not be
  // decoded as an instruction, so the sequencer waits for it in ST_IMM.
  always @* begin
    case (state_r)
      ST_IDLE: begin
        if (instr_valid && op == `OP_LOAD && ld_scls == `CLS_LIMM) begin
          state_nxt = ST_IMM;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IMM: begin
        state_nxt = instr_valid ? ST_IDLE : ST_IMM;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Decoded outputs
  // --------------------------------------------------------------------------
  // All outputs come from flip-flops one cycle after the last word is taken.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      dec_valid_r <= 1'b0;
      exec_valid_r <= 1'b0;
      illegal_r <= 1'b0;
      illegal_cause_r <= `CAUSE_NONE;
      dec_op_r <= 4'h0;
      dest_cls_r <= `CLS_HWREGS;
      src_cls_r <= `CLS_HWREGS;
      dest_reg_r <= 4'h0;
      src_reg_r <= 4'h0;
      imm_r <= 16'h0000;
      bank_sw_r <= 1'b0;
      src1_bank_r <= `BANK_ONE;
      src2_bank_r <= `BANK_ZERO;
      ptr1_r <= 2'h0;
      ptr2_r <= 2'h0;
      ptr2_mod_r <= 2'h0;
      hold_illegal_r <= 1'b0;
      hold_cause_r <= `CAUSE_NONE;
      hold_dcls_r <= `CLS_HWREGS;
      hold_dreg_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      dec_valid_r <= 1'b0;
      exec_valid_r <= 1'b0;
      if (instr_valid && state_r == ST_IMM) begin
        // Second word of a long-immediate load completes the instruction.
        dec_valid_r <= 1'b1;
        exec_valid_r <= ~hold_illegal_r;
        illegal_r <= hold_illegal_r;
        illegal_cause_r <= hold_cause_r;
        dec_op_r <= `OP_LOAD;
        dest_cls_r <= hold_dcls_r;
        src_cls_r <= `CLS_LIMM;
        dest_reg_r <= hold_dreg_r;
        src_reg_r <= 4'h0;
        imm_r <= instr_word;
      end else if (instr_valid && state_nxt == ST_IMM) begin
        hold_illegal_r <= ld_illegal;
        hold_cause_r <= ld_cause;
        hold_dcls_r <= ld_dcls;
        hold_dreg_r <= ld_reg;
      end else if (instr_valid) begin
        dec_valid_r <= 1'b1;
        dec_op_r <= op;
        if (is_mul(op)) begin
          // A rejected multiply never reaches the datapath.
          illegal_r <= mul_illegal;
          illegal_cause_r <= mul_cause;
          exec_valid_r <= ~mul_illegal;
          dest_cls_r <= instr_word[`MUL_S1_KIND] ? `CLS_REGIND : `CLS_HWREGS;
          src_cls_r <= `CLS_REGIND;
          dest_reg_r <= instr_word[`MUL_S1_MSB:`MUL_S1_LSB];
          src_reg_r <= 4'h0;
          bank_sw_r <= mul_bank_sw;
          src1_bank_r <= `BANK_ONE;
          src2_bank_r <= mul_src2_bank;
          ptr1_r <= instr_word[`MUL_S1_PTR_MSB:`MUL_S1_PTR_LSB];
          ptr2_r <= instr_word[`MUL_S2_PTR_MSB:`MUL_S2_PTR_LSB];
          ptr2_mod_r <= instr_word[`MUL_S2_MOD_MSB:`MUL_S2_MOD_LSB];
        end else begin
          illegal_r <= ld_illegal;
          illegal_cause_r <= ld_cause;
          exec_valid_r <= ~ld_illegal;
          if (op == `OP_LOAD_HH) begin
            dest_cls_r <= `CLS_HWREGS;
            src_cls_r <= `CLS_HWREGS;
            dest_reg_r <= hh_dst;
            src_reg_r <= hh_src;
          end else begin
            // Other opcodes pass through with their raw fields.
            dest_cls_r <= ld_dcls;
            src_cls_r <= ld_scls;
            dest_reg_r <= ld_reg;
            src_reg_r <= 4'h0;
          end
        end
      end
    end
  end

endmodule

//--- rtl/dsp_decode_defines.vh
// Constants for the operand legality decoder of the 16-bit DSP core.
// Assumes a 16-bit instruction word; the field layout below is the core's own.
`ifndef DSP_DECODE_DEFINES_VH
`define DSP_DECODE_DEFINES_VH

// ----------------------------------------------------------------------------
// Opcode field and the opcodes this block checks
// ----------------------------------------------------------------------------
`define OP_MSB 15
`define OP_LSB 12
`define OP_LOAD 4'h1
`define OP_LOAD_HH 4'h2
`define OP_MUL_LOAD 4'h8
`define OP_MUL_ACC 4'h9
`define OP_MUL_SUB 4'ha

// ----------------------------------------------------------------------------
// General load layout: classes and one hardware-register index
// ----------------------------------------------------------------------------
`define LD_DCLS_MSB 11
`define LD_DCLS_LSB 9
`define LD_SCLS_MSB 8
`define LD_SCLS_LSB 6
`define LD_REG_MSB 5
`define LD_REG_LSB 2
// Hardware-register to hardware-register load layout.
`define HH_DST_MSB 7
`define HH_DST_LSB 4
`define HH_SRC_MSB 3
`define HH_SRC_LSB 0

// ----------------------------------------------------------------------------
// Operand classes
// ----------------------------------------------------------------------------
`define CLS_HWREGS 3'h0
`define CLS_DREGS 3'h1
`define CLS_PREGS 3'h2
`define CLS_REGIND 3'h3
`define CLS_MEMIND 3'h4
`define CLS_ACCIND 3'h5
`define CLS_LIMM 3'h6
`define CLS_DIRECT 3'h7

// ----------------------------------------------------------------------------
// Hardware-register codes; codes with the top bit set are offchip_reg_n
// ----------------------------------------------------------------------------
`define HW_ACC 4'h0
`define HW_X 4'h1
`define HW_Y 4'h2
`define HW_PROD 4'h3
`define HW_STATUS 4'h4
`define HW_PC 4'h5
`define HW_EXT_BIT 3

// ----------------------------------------------------------------------------
// Multiply layout (multiply_load_op, multiply_accumulate_op, multiply_subtract_op)
// ----------------------------------------------------------------------------
`define MUL_S1_KIND 11
`define MUL_S1_MSB 10
`define MUL_S1_LSB 7
`define MUL_S1_PTR_MSB 10
`define MUL_S1_PTR_LSB 9
`define MUL_S1_BANK 8
`define MUL_S2_PTR_MSB 6
`define MUL_S2_PTR_LSB 5
`define MUL_S2_BANK 4
`define MUL_S2_MOD_MSB 3
`define MUL_S2_MOD_LSB 2
`define MUL_SW_GIVEN 1
`define MUL_SW_ON 0
`define BANK_ONE 1'b1
`define BANK_ZERO 1'b0

// ----------------------------------------------------------------------------
// Illegal-operand cause codes
// ----------------------------------------------------------------------------
`define CAUSE_NONE 4'h0
`define CAUSE_DST_PROD 4'h1
`define CAUSE_EXT_SAME 4'h2
`define CAUSE_X_SAME 4'h3
`define CAUSE_SR_SAME 4'h4
`define CAUSE_ACCIND_ACC 4'h5
`define CAUSE_S1_BANK 4'h6
`define CAUSE_S2_BANK 4'h7
`define CAUSE_S1_X 4'h8
`define CAUSE_BAD_DEST 4'h9

`endif

//--- rtl/mul_operand_check.v
// Operand checker and bank selection for the three multiply instructions.
// Assumes the caller only uses the outputs when the opcode is a multiply.
`timescale 1ns/1ps
`include "dsp_decode_defines.vh"

module mul_operand_check (
  input wire [15:0] word,
  output reg illegal,
  output reg [3:0] cause,
  output reg bank_sw,
  output reg src2_bank
);

  // --------------------------------------------------------------------------
  // Legality and bank switch default
  // --------------------------------------------------------------------------
  // Checks run in a fixed order so that one cause is reported even when
  // several constraints are broken at once.
  always @* begin
    illegal = 1'b0;
    cause = `CAUSE_NONE;
    if (word[`MUL_S1_KIND] && word[`MUL_S1_BANK] != `BANK_ONE) begin
      illegal = 1'b1;
      cause = `CAUSE_S1_BANK;
    end else if (word[`MUL_S2_BANK] != `BANK_ZERO) begin
      illegal = 1'b1;
      cause = `CAUSE_S2_BANK;
    end else if (!word[`MUL_S1_KIND] && word[`MUL_S1_MSB:`MUL_S1_LSB] == `HW_X) begin
      illegal = 1'b1;
      cause = `CAUSE_S1_X;
    end
    // An explicit switch operand wins; otherwise the form picks the default.
    if (word[`MUL_SW_GIVEN]) begin
      bank_sw = word[`MUL_SW_ON];
    end else if (word[`MUL_S1_KIND]) begin
      bank_sw = 1'b1;
    end else begin
      bank_sw = 1'b0;
    end
    // With the switch OFF the second factor is fetched from bank 1, the same
    // bank as the first, so one stored value can be multiplied by itself.
    src2_bank = bank_sw ? `BANK_ZERO : `BANK_ONE;
  end

endmodule

//--- bench/prog_mem_model.sv
// Program memory model that hands instruction words to the decoder.
// Assumes the bench fills mem by reference and asks for one address per fetch.
`timescale 1ns/1ps
module prog_mem_model (
  input wire ref_clk,
  input wire rst_n,
  input wire fetch,
  input wire [5:0] fetch_addr,
  input wire slow,
  output reg instr_valid = 1'b0,
  output reg [15:0] instr_word = 16'h0000
);
  reg [15:0] mem [0:63];
  reg hold_r = 1'b0;
  reg [5:0] addr_r = 6'h00;

  // A slow fetch costs one extra cycle. Between words the bus toggles every cycle
  // between the last word and its inverse, so a decoder that samples it unqualified sees junk.
  always @(posedge ref_clk) begin
    hold_r <= fetch && slow && rst_n;
    addr_r <= fetch_addr;
    instr_valid <= rst_n && ((fetch && !slow) || hold_r);
    if (fetch && !slow)
      instr_word <= mem[fetch_addr];
    else if (hold_r)
      instr_word <= mem[addr_r];
    else
      instr_word <= ~instr_word;
  end
endmodule

//--- bench/dsp_decode_chk.sv
// Port-level assertions for the operand legality decoder.
// Assumes one clock domain and one program word per valid cycle.
`timescale 1ns/1ps
module dsp_decode_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire dec_valid_r,
  input wire exec_valid_r,
  input wire illegal_r,
  input wire [3:0] illegal_cause_r,
  input wire [15:0] imm_r,
  input wire bank_sw_r,
  input wire src1_bank_r,
  input wire src2_bank_r
);
  // --------------------------------------------------------------------------
  // Helper logic
  // --------------------------------------------------------------------------
  // The word after a two-word load is an immediate, so it is never judged as an opcode.
  reg pend_r;
  wire [3:0] op = instr_word[15:12];
  wire tk = instr_valid && !pend_r;
  wire lw = (op == 4'h1) && (instr_word[8:6] == 3'h6);
  wire mul = tk && ((op == 4'h8) || (op == 4'h9) || (op == 4'ha));
  wire hh = tk && (op == 4'h2);
  wire [3:0] hd = instr_word[7:4];
  wire sw_exp = instr_word[1] ? instr_word[0] : instr_word[11];
  always @(posedge ref_clk) begin
    if (!rst_n)
      pend_r <= 1'b0;
    else if (instr_valid)
      pend_r <= !pend_r && lw;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  answer_one_cycle_a: assert property (tk && !lw |=> dec_valid_r)
    else $error("no decode one cycle after a word");
  imm_pair_a: assert property (instr_valid && pend_r |=> dec_valid_r && imm_r == $past(instr_word))
    else $error("immediate word not paired");
  exec_legal_a: assert property (exec_valid_r == (dec_valid_r && !illegal_r))
    else $error("execute strobe disagrees with legality");
  prod_dest_a: assert property (hh && hd == 4'h3 |=> illegal_r && illegal_cause_r == 4'h1)
    else $error("product register destination accepted");
  ext_same_a: assert property (hh && hd[3] && hd == instr_word[3:0] |=> illegal_cause_r == 4'h2)
    else $error("same offchip register accepted");
  status_same_a: assert property (hh && hd == 4'h4 && instr_word[3:0] == 4'h4 |=> illegal_cause_r == 4'h4)
    else $error("status to status load accepted");
  accind_acc_a: assert property (tk && op == 4'h1 && instr_word[11:2] == 10'h050 |=> illegal_cause_r == 4'h5)
    else $error("accumulator-indirect into accumulator accepted");
  src1_bank_a: assert property (mul && instr_word[11] && !instr_word[8] |=> illegal_r && illegal_cause_r == 4'h6 && src1_bank_r)
    else $error("first pointer from wrong bank accepted");
  src2_bank_a: assert property (mul && !(instr_word[11] && !instr_word[8]) && instr_word[4] |=> illegal_cause_r == 4'h7)
    else $error("second pointer from wrong bank accepted");
  src1_x_a: assert property (mul && !instr_word[11] && instr_word[10:7] == 4'h1 && !instr_word[4] |=> illegal_cause_r == 4'h8)
    else $error("X as first factor accepted");
  switch_sel_a: assert property (mul |=> bank_sw_r == $past(sw_exp) && src2_bank_r == !bank_sw_r)
    else $error("bank switch setting wrong");

  illegal_seen_c: cover property (dec_valid_r && illegal_r);
  square_seen_c: cover property (exec_valid_r && !bank_sw_r);
  pair_seen_c: cover property (instr_valid && pend_r);
endmodule

bind dsp_operand_legality_decode dsp_decode_chk u_dsp_decode_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .instr_valid(instr_valid), .instr_word(instr_word), .dec_valid_r(dec_valid_r),
  .exec_valid_r(exec_valid_r), .illegal_r(illegal_r), .illegal_cause_r(illegal_cause_r),
  .imm_r(imm_r), .bank_sw_r(bank_sw_r), .src1_bank_r(src1_bank_r), .src2_bank_r(src2_bank_r));

//--- bench/dsp_operand_legality_decode_test.sv
// Self-checking bench for the operand legality decoder.
// Assumes prog_mem_model as program memory and a 100 MHz ref_clk.
`timescale 1ns/1ps
module dsp_operand_legality_decode_test;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg fetch = 1'b0;
  reg [5:0] fetch_addr = 6'h00;
  reg slow = 1'b0;
  wire instr_valid, dec_valid_r, exec_valid_r, illegal_r, bank_sw_r, src1_bank_r, src2_bank_r;
  wire [15:0] instr_word, imm_r;
  wire [3:0] illegal_cause_r, dec_op_r, dest_reg_r, src_reg_r;
  wire [2:0] dest_cls_r, src_cls_r;
  wire [1:0] ptr1_r, ptr2_r, ptr2_mod_r;
  // Row: word, expected cause (zero means legal), bank check enable, expected switch.
  logic [21:0] rows [0:24];
  integer err_count = 0;
  integer checked = 0;
  integer i;

  prog_mem_model u_prog_mem_model (.ref_clk(ref_clk), .rst_n(rst_n), .fetch(fetch),
    .fetch_addr(fetch_addr), .slow(slow), .instr_valid(instr_valid), .instr_word(instr_word));
  dsp_operand_legality_decode u_dsp_operand_legality_decode (.ref_clk(ref_clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_word(instr_word), .dec_valid_r(dec_valid_r),
    .exec_valid_r(exec_valid_r), .illegal_r(illegal_r), .illegal_cause_r(illegal_cause_r),
    .dec_op_r(dec_op_r), .dest_cls_r(dest_cls_r), .src_cls_r(src_cls_r), .dest_reg_r(dest_reg_r),
    .src_reg_r(src_reg_r), .imm_r(imm_r), .bank_sw_r(bank_sw_r), .src1_bank_r(src1_bank_r),
    .src2_bank_r(src2_bank_r), .ptr1_r(ptr1_r), .ptr2_r(ptr2_r), .ptr2_mod_r(ptr2_mod_r));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic stop_test;
    begin
      if (err_count == 0 && checked > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask

  task automatic chk(input bit ok, input string msg);
    begin
      checked = checked + 1;
      if (!ok) begin
        err_count = err_count + 1;
        $display("MISMATCH %0t %s", $time, msg);
      end
    end
  endtask

  task automatic feed(input [5:0] a, input reg s);
    begin
      @(posedge ref_clk);
      fetch <= 1'b1;
      fetch_addr <= a;
      slow <= s;
    end
  endtask

  // Bounded wait so a decoder that never answers still reaches the verdict.
  task automatic await_dec;
    integer n;
    begin
      @(posedge ref_clk);
      fetch <= 1'b0;
      n = 0;
      while (dec_valid_r !== 1'b1 && n < 8) begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end
      chk(n < 8, "decode answer missing");
      if (n >= 8) stop_test;
    end
  endtask

  task automatic check_row(input integer k);
    reg [21:0] r;
    reg [15:0] w;
    begin
      r = rows[k];
      w = r[21:6];
      chk(illegal_r === (r[5:2] != 4'h0) && exec_valid_r === (r[5:2] == 4'h0), "legal flag");
      chk(illegal_cause_r === r[5:2] && dec_op_r === r[21:18], "cause or opcode");
      if (r[1]) chk(bank_sw_r === r[0] && src2_bank_r === !r[0] && src1_bank_r === 1'b1, "bank");
      // Load and hh operand fields must reach the outputs whatever the legality verdict; pointer fields are checked only on bank-checked rows.
      if (w[15:12] == 4'h1)
        chk({dest_cls_r, src_cls_r, dest_reg_r} === w[11:2], "load fields");
      if (w[15:12] == 4'h2)
        chk({src_cls_r, dest_reg_r, src_reg_r} === {3'h0, w[7:0]}, "hh fields");
      if (r[1])
        chk({ptr1_r, ptr2_r, ptr2_mod_r} === {w[10:9], w[6:5], w[3:2]}, "ptrs");
    end
  endtask

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    rows = '{{16'h104c, 4'h1, 2'h0}, {16'h1044, 4'h0, 2'h0}, {16'h1140, 4'h5, 2'h0},
      {16'h1144, 4'h0, 2'h0}, {16'h2099, 4'h2, 2'h0}, {16'h2098, 4'h0, 2'h0},
      {16'h2011, 4'h3, 2'h0}, {16'h2044, 4'h4, 2'h0}, {16'h2012, 4'h0, 2'h0},
      {16'h2030, 4'h1, 2'h0}, {16'h8800, 4'h6, 2'h0}, {16'h8910, 4'h7, 2'h0},
      {16'h8080, 4'h8, 2'h0}, {16'h8900, 4'h0, 2'h3}, {16'h8000, 4'h0, 2'h2},
      {16'h8003, 4'h0, 2'h3}, {16'h8902, 4'h0, 2'h2}, {16'h9080, 4'h8, 2'h0},
      {16'ha800, 4'h6, 2'h0}, {16'h9900, 4'h0, 2'h3}, {16'ha000, 4'h0, 2'h2},
      {16'ha910, 4'h7, 2'h0}, {16'h0000, 4'h0, 2'h0}, {16'h9f4d, 4'h0, 2'h3},
      {16'h1840, 4'h9, 2'h0}};
    for (i = 0; i < 25; i = i + 1) u_prog_mem_model.mem[i] = rows[i][21:6];
    u_prog_mem_model.mem[40] = 16'h118c;
    u_prog_mem_model.mem[41] = 16'h8080;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk(dec_valid_r === 1'b0 && illegal_r === 1'b0 && src1_bank_r === 1'b1, "reset value");
    // Table rows, alternating prompt and slow program memory.
    for (i = 0; i < 25; i = i + 1) begin
      feed(i[5:0], i[0]);
      await_dec;
      check_row(i);
    end
    // Two-word load into the product register with idle cycles between its words.
    feed(6'd40, 1'b0);
    @(posedge ref_clk);
    fetch <= 1'b0;
    repeat (3) begin
      @(posedge ref_clk);
      #1;
      chk(dec_valid_r === 1'b0, "first word answered");
    end
    feed(6'd41, 1'b1);
    await_dec;
    chk(illegal_cause_r === 4'h1 && imm_r === 16'h8080 && src_cls_r === 3'h6, "pair");
    // Back-to-back multiplies: a bad first bank, then a legal square.
    feed(6'd10, 1'b0);
    feed(6'd14, 1'b0);
    @(posedge ref_clk);
    fetch <= 1'b0;
    #1;
    chk(dec_valid_r === 1'b1 && illegal_cause_r === 4'h6, "first of pair");
    @(posedge ref_clk);
    #1;
    chk(exec_valid_r === 1'b1 && src2_bank_r === 1'b1, "square");
    // Reset in mid-flight swallows the word and restores the reset state.
    feed(6'd13, 1'b0);
    @(posedge ref_clk);
    fetch <= 1'b0;
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk(dec_valid_r === 1'b0 && bank_sw_r === 1'b0 && src1_bank_r === 1'b1, "mid reset");
    feed(6'd13, 1'b0);
    await_dec;
    check_row(13);
    stop_test;
  end
endmodule
